//--- bench/ptmc_assertions.sv
// Port-level checker for the port toggle and miscellaneous block
`timescale 1ns/10ps
`default_nettype none
module ptmc_assertions
  import ptmc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        prescaler1_out,
  input wire logic        prescaler2_out,
  input wire logic        timer_a_clk_sel,
  input wire logic        timer_b_clk_sel,
  input wire logic        first_prescaler_preset,
  input wire logic        second_prescaler_preset,
  input wire logic        aux_counter_preset,
  input wire logic        reset_pin_pulldown,
  input wire logic        ext_irq_two_request,
  input wire logic [7:0]  porta_oe,
  input wire logic [1:0]  portc_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic misc_wr;
  assign misc_wr = avs_write && avs_address == OFS_MISC && avs_byteenable[0];
  sequence s_rd_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_read_two_cycle: assert property ($rose(avs_read) |-> s_rd_answer) else $error("read answer late");
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  a_ps1_preset: assert property (first_prescaler_preset == (misc_wr && avs_writedata[MR_PS1_PRE]))
    else $error("first preset mismatch");
  a_ps2_preset: assert property (second_prescaler_preset == (misc_wr && avs_writedata[MR_PS2_PRE]))
    else $error("second preset mismatch");
  a_aux_preset_cause: assert property (aux_counter_preset |-> misc_wr) else $error("stray aux preset");
  a_clk_route: assert property ((timer_a_clk_sel == prescaler1_out && timer_b_clk_sel == prescaler2_out)
    || (timer_a_clk_sel == prescaler2_out && timer_b_clk_sel == prescaler1_out)) else $error("bad clock route");
  a_dir_after_reset: assert property ($past(!rst_n) |-> porta_oe == 8'h00 && portc_oe == 2'h0)
    else $error("directions not input");
  a_aux_mask_holds: assert property ($past(misc_wr && avs_writedata[MR_AUX_MASK]) |-> !reset_pin_pulldown)
    else $error("masked pulldown active");
  a_irq2_mask_holds: assert property ($past(misc_wr && avs_writedata[MR_IRQ2_MASK]) |-> !ext_irq_two_request)
    else $error("masked request active");
endmodule : ptmc_assertions
bind ptmc_top ptmc_assertions i_ptmc_assertions (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .prescaler1_out, .prescaler2_out, .timer_a_clk_sel,
  .timer_b_clk_sel, .first_prescaler_preset, .second_prescaler_preset, .aux_counter_preset,
  .reset_pin_pulldown, .ext_irq_two_request, .porta_oe, .portc_oe);
`default_nettype wire

//--- bench/ptmc_pin_model.sv
// External port lines with pull-ups
`timescale 1ns/10ps
`default_nettype none
module ptmc_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  output logic      [W-1:0] pin
);
  // Released lines rise to the pull-up, never hold the last value
  assign pin = (drv_out & drv_oe) | ~drv_oe;
endmodule : ptmc_pin_model
`default_nettype wire

//--- bench/ptmc_top_bench.sv
// Self-checking bench for the port toggle and miscellaneous block
`timescale 1ns/10ps
`default_nettype none
module ptmc_top_bench;
  import ptmc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, prescaler1_out = 1'b1;
  logic prescaler2_out = 1'b0, timer_a_overflow = 1'b0, timer_b_overflow = 1'b0, aux_counter_overflow = 1'b0;
  logic second_ext_irq_pin = 1'b1, avs_waitrequest, timer_a_clk_sel, timer_b_clk_sel, first_prescaler_preset;
  logic second_prescaler_preset, aux_counter_preset, reset_pin_pulldown, ext_irq_two_request, irq;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [7:0]  porta_out, porta_oe, porta_pin_in;
  logic [3:0]  portb_out, portb_oe, portb_pin_in;
  logic [1:0]  portc_out, portc_oe, portc_pin_in;
  ptmc_serial_s serial = '0;
  int          n_errors = 0, check_count = 0, cyc = 0;
  // Preset strobes last one write cycle, so count them at every edge
  int          n_pre1 = 0, n_pre2 = 0, n_aux = 0;
  ptmc_top i_ptmc_top (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .timer_a_overflow, .timer_b_overflow,
    .prescaler1_out, .prescaler2_out, .aux_counter_overflow, .serial, .second_ext_irq_pin, .porta_pin_in,
    .portb_pin_in, .portc_pin_in, .porta_out, .porta_oe, .portb_out, .portb_oe, .portc_out, .portc_oe,
    .timer_a_clk_sel, .timer_b_clk_sel, .first_prescaler_preset, .second_prescaler_preset,
    .aux_counter_preset, .reset_pin_pulldown, .ext_irq_two_request, .irq);
  ptmc_pin_model #(.W(8)) i_pins_a (.drv_out(porta_out), .drv_oe(porta_oe), .pin(porta_pin_in));
  ptmc_pin_model #(.W(4)) i_pins_b (.drv_out(portb_out), .drv_oe(portb_oe), .pin(portb_pin_in));
  ptmc_pin_model #(.W(2)) i_pins_c (.drv_out(portc_out), .drv_oe(portc_oe), .pin(portc_pin_in));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    n_pre1 += int'(first_prescaler_preset);
    n_pre2 += int'(second_prescaler_preset);
    n_aux  += int'(aux_counter_preset);
    if (cyc == 2000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    chk(avs_readdata[7:0], exp);
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic ovf(input logic a, input logic b, input logic x);
    timer_a_overflow     <= a;
    timer_b_overflow     <= b;
    aux_counter_overflow <= x;
    @(posedge clk);
    timer_a_overflow     <= 1'b0;
    timer_b_overflow     <= 1'b0;
    aux_counter_overflow <= 1'b0;
    @(posedge clk);
  endtask : ovf
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_PORTA_DIR, READS_ONES);
    rd(OFS_PORTC_DIR, READS_ONES);
    rd(OFS_PORTB_DCR, READS_ONES);
    rd(OFS_MISC, 8'h50);
    rd(OFS_PORTA, 8'hff);
    rd(4'hf, 8'h00);
    wr(OFS_PORTA_DIR, 8'h0f);
    chk(porta_oe, 8'h0f);
    wr(OFS_PORTA, 8'h5a);
    chk(porta_out, 8'h5a);
    rd(OFS_PORTA, 8'hfa);
    wr(OFS_PORTC_DIR, 8'h01);
    wr(OFS_PORTC, 8'h02);
    chk({4'h0, portc_oe, portc_out}, 8'h06);
    rd(OFS_PORTC, 8'h02);
    wr(OFS_PORTB, 8'h0a);
    wr(OFS_PORTB_DCR, 8'hff);
    chk({portb_oe, portb_out}, 8'hfa);
    ovf(1'b0, 1'b1, 1'b0);
    chk({portb_oe, portb_out}, 8'hfa);
    wr(OFS_PORTB_DCR, 8'h0f);
    chk({portb_oe, portb_out}, 8'h5a);
    ovf(1'b0, 1'b1, 1'b0);
    chk({4'h0, portb_out}, 8'h0b);
    ovf(1'b1, 1'b0, 1'b0);
    chk({4'h0, portb_out}, 8'h0b);
    serial <= ptmc_serial_s'(4'b0111);
    ovf(1'b1, 1'b0, 1'b0);
    chk({4'h0, portb_out}, 8'h09);
    wr(OFS_PORTB, 8'h00);
    chk({4'h0, portb_out}, 8'h01);
    rd(OFS_PORTB, 8'h01);
    wr(OFS_MISC, 8'h51);
    ovf(1'b1, 1'b0, 1'b0);
    chk({4'h0, portb_out}, 8'h00);
    ovf(1'b0, 1'b1, 1'b0);
    chk({4'h0, portb_out}, 8'h02);
    chk({6'h0, timer_a_clk_sel, timer_b_clk_sel}, 8'h02);
    wr(OFS_MISC, 8'h53);
    chk({6'h0, timer_a_clk_sel, timer_b_clk_sel}, 8'h01);
    wr(OFS_MISC, 8'h5f);
    rd(OFS_MISC, 8'h53);
    second_ext_irq_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd(OFS_MISC, 8'hd3);
    chk({6'h0, ext_irq_two_request, irq}, 8'h00);
    wr(OFS_MISC, 8'h93);
    chk({7'h0, ext_irq_two_request}, 8'h01);
    wr(OFS_IRQ_MASK, 8'h03);
    chk({7'h0, irq}, 8'h01);
    wr(OFS_IRQ_STAT, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rd(OFS_MISC, 8'h93);
    wr(OFS_MISC, 8'h13);
    chk({7'h0, ext_irq_two_request}, 8'h00);
    ovf(1'b0, 1'b0, 1'b1);
    rd(OFS_MISC, 8'h33);
    chk({6'h0, reset_pin_pulldown, irq}, 8'h01);
    rd(OFS_IRQ_STAT, 8'h02);
    wr(OFS_MISC, 8'h23);
    chk({7'h0, reset_pin_pulldown}, 8'h01);
    wr(OFS_MISC, 8'h03);
    rd(OFS_MISC, 8'h03);
    wr(OFS_MISC, 8'h23);
    rd(OFS_MISC, 8'h03);
    chk({n_pre1[3:0], n_pre2[3:0]}, 8'h11);
    chk(n_aux[7:0], 8'h02);
    end_sim();
  end
endmodule : ptmc_top_bench
`default_nettype wire

//--- rtl/ptmc_pkg.sv
// Package for the port toggle and miscellaneous control block
// Summary of operation
// - Overflow swap selects which timer toggles lines
// - Line0 toggles only when its disable bit clear
// - Line1 toggle enable from serial control terms
// - Toggle-enabled line ignores CPU data writes
// - Drive-type bits: zero open-drain, one push-pull
// - Low nibble is direction; register reads ones
// - Port A/C directions reset input, read ones
// - Miscellaneous register decoded at fixed address
// - Falling pin edge sets second interrupt flag
// - Set mask blocks second interrupt request
// - Aux overflow sets flag; unmasked flag resets
// - Writing inverse of flag bit presets auxiliary counter
// - Set reset mask blocks reset pull-down
// - First preset bit loads prescaler, reads zero
// - Second preset bit loads prescaler, reads zero
// - Prescaler swap selects timer clock sources
// - Second interrupt flag never auto-cleared
// - Data read: pin when input, latch when output
package ptmc_pkg;
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_PORTA    = 4'h0;
  localparam logic [3:0]  OFS_PORTB    = 4'h1;
  localparam logic [3:0]  OFS_PORTC    = 4'h2;
  localparam logic [3:0]  OFS_PORTA_DIR = 4'h4;
  localparam logic [3:0]  OFS_PORTB_DCR = 4'h5;
  localparam logic [3:0]  OFS_PORTC_DIR = 4'h6;
  localparam logic [3:0]  OFS_MISC     = 4'ha;
  localparam logic [3:0]  OFS_IRQ_STAT = 4'hc;
  localparam logic [3:0]  OFS_IRQ_MASK = 4'hd;
  // Miscellaneous register bit positions
  localparam int          MR_OVF_SWAP  = 0;
  localparam int          MR_PS_SWAP   = 1;
  localparam int          MR_PS2_PRE   = 2;
  localparam int          MR_PS1_PRE   = 3;
  localparam int          MR_AUX_MASK  = 4;
  localparam int          MR_AUX_FLAG  = 5;
  localparam int          MR_IRQ2_MASK = 6;
  localparam int          MR_IRQ2_FLAG = 7;
  localparam int          DCR_L0_TDIS  = 4;
  localparam logic [7:0]  DCR_RESET    = 8'hf0;
  localparam logic [7:0]  MISC_RESET   = 8'h50;
  localparam logic [7:0]  READS_ONES   = 8'hff;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
  // Interrupt status bits: 0 irq2 edge, 1 aux overflow
  localparam int          IRQ_W        = 2;

  typedef struct packed {
    logic serial_irq_flag;
    logic serial_transaction_enable;
    logic line1_toggle_enable_bit;
    logic clock_arbitration_state;
  } ptmc_serial_s;

  typedef struct packed {
    logic [7:0] porta_data;
    logic [7:0] porta_direction;
    logic [3:0] portb_data;
    logic [7:0] portb_data_control;
    logic [1:0] portc_data;
    logic [1:0] portc_direction;
    logic [7:0] misc;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0] irq2_sync;
    logic       irq2_prev;
    logic [31:0] readdata;
    logic       rd_done;
  } ptmc_state_s;
endpackage : ptmc_pkg

//--- rtl/ptmc_top.sv
// Port toggle routing, port control and miscellaneous register
`timescale 1ns/10ps
`default_nettype none
module ptmc_top (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [ptmc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      timer_a_overflow,
  input  wire logic                      timer_b_overflow,
  input  wire logic                      prescaler1_out,
  input  wire logic                      prescaler2_out,
  input  wire logic                      aux_counter_overflow,
  input  wire ptmc_pkg::ptmc_serial_s    serial,
  input  wire logic                      second_ext_irq_pin,
  input  wire logic [7:0]                porta_pin_in,
  input  wire logic [3:0]                portb_pin_in,
  input  wire logic [1:0]                portc_pin_in,
  output logic      [7:0]                porta_out,
  output logic      [7:0]                porta_oe,
  output logic      [3:0]                portb_out,
  output logic      [3:0]                portb_oe,
  output logic      [1:0]                portc_out,
  output logic      [1:0]                portc_oe,
  output logic                           timer_a_clk_sel,
  output logic                           timer_b_clk_sel,
  output logic                           first_prescaler_preset,
  output logic                           second_prescaler_preset,
  output logic                           aux_counter_preset,
  output logic                           reset_pin_pulldown,
  output logic                           ext_irq_two_request,
  output logic                           irq
);
  import ptmc_pkg::*;

  ptmc_state_s s;
  ptmc_state_s next_s;
  logic [7:0]  pa_sync1, pa_sync2;
  logic [3:0]  pb_sync1, pb_sync2;
  logic [1:0]  pc_sync1, pc_sync2;

  // Pin inputs pass two flops before any logic looks at them
  always_ff @(posedge clk) begin
    pa_sync1 <= porta_pin_in;
    pa_sync2 <= pa_sync1;
    pb_sync1 <= portb_pin_in;
    pb_sync2 <= pb_sync1;
    pc_sync1 <= portc_pin_in;
    pc_sync2 <= pc_sync1;
  end

  logic       wr;
  logic       rd;
  logic [7:0] wd;
  logic       line0_pulse;
  logic       line1_pulse;
  logic       line0_ten;
  logic       line1_ten;
  logic [7:0] pa_rd;
  logic [3:0] pb_rd;
  logic [1:0] pc_rd;
  logic       irq2_fall;
  logic       aux_wr_preset;

  assign wr = avs_write & avs_byteenable[0];
  assign rd = avs_read;
  assign wd = avs_writedata[7:0];

  // Single-cycle waitrequest on reads lets readdata come from a flop
  assign avs_waitrequest = avs_read & ~s.rd_done;
  assign avs_readdata    = s.readdata;

  always_comb begin
    line0_pulse = s.misc[MR_OVF_SWAP] ? timer_a_overflow : timer_b_overflow;
    line1_pulse = s.misc[MR_OVF_SWAP] ? timer_b_overflow : timer_a_overflow;
    line0_ten   = ~s.portb_data_control[DCR_L0_TDIS];
    line1_ten   = ((serial.serial_irq_flag & serial.serial_transaction_enable
                    & (s.portb_data[0] | s.portb_data_control[0]))
                   | (serial.line1_toggle_enable_bit & serial.serial_transaction_enable))
                  & serial.clock_arbitration_state;
    pa_rd = (s.porta_direction & s.porta_data) | (~s.porta_direction & pa_sync2);
    pb_rd = (s.portb_data_control[3:0] & s.portb_data) | (~s.portb_data_control[3:0] & pb_sync2);
    pc_rd = (s.portc_direction & s.portc_data) | (~s.portc_direction & pc_sync2);
    irq2_fall = s.irq2_prev & ~s.irq2_sync[1];
    aux_wr_preset = 1'b0;
    if (wr && avs_address == OFS_MISC) begin
      aux_wr_preset = s.misc[MR_AUX_FLAG] ? ~wd[MR_AUX_FLAG] : wd[MR_AUX_FLAG];
    end
  end

  always_comb begin
    next_s = s;
    next_s.irq2_sync = {s.irq2_sync[0], second_ext_irq_pin};
    next_s.irq2_prev = s.irq2_sync[1];
    next_s.rd_done   = avs_read & ~s.rd_done;
    if (wr) begin
      if (avs_address == OFS_PORTA) begin
        next_s.porta_data = wd;
      end else if (avs_address == OFS_PORTB) begin
        next_s.portb_data[3:2] = wd[3:2];
        if (!line1_ten) begin
          next_s.portb_data[1] = wd[1];
        end
        if (!line0_ten) begin
          next_s.portb_data[0] = wd[0];
        end
      end else if (avs_address == OFS_PORTC) begin
        next_s.portc_data = wd[1:0];
      end else if (avs_address == OFS_PORTA_DIR) begin
        next_s.porta_direction = wd;
      end else if (avs_address == OFS_PORTB_DCR) begin
        next_s.portb_data_control = wd;
      end else if (avs_address == OFS_PORTC_DIR) begin
        next_s.portc_direction = wd[1:0];
      end else if (avs_address == OFS_MISC) begin
        next_s.misc[MR_OVF_SWAP]  = wd[MR_OVF_SWAP];
        next_s.misc[MR_PS_SWAP]   = wd[MR_PS_SWAP];
        next_s.misc[MR_AUX_MASK]  = wd[MR_AUX_MASK];
        next_s.misc[MR_IRQ2_MASK] = wd[MR_IRQ2_MASK];
        if (s.misc[MR_AUX_FLAG] && !wd[MR_AUX_FLAG]) begin
          next_s.misc[MR_AUX_FLAG] = 1'b0;
        end
        if (!wd[MR_IRQ2_FLAG]) begin
          next_s.misc[MR_IRQ2_FLAG] = 1'b0;
        end
      end else if (avs_address == OFS_IRQ_STAT) begin
        next_s.irq_status = s.irq_status & ~wd[IRQ_W-1:0];
      end else if (avs_address == OFS_IRQ_MASK) begin
        next_s.irq_mask = wd[IRQ_W-1:0];
      end
    end
    // Toggles placed after writes so a same-cycle pulse wins
    if (line0_pulse && line0_ten) begin
      next_s.portb_data[0] = ~s.portb_data[0];
    end
    if (line1_pulse && line1_ten) begin
      next_s.portb_data[1] = ~s.portb_data[1];
    end
    // Hardware sets come last: set beats clear
    if (irq2_fall) begin
      next_s.misc[MR_IRQ2_FLAG] = 1'b1;
      next_s.irq_status[0] = 1'b1;
    end
    if (aux_counter_overflow) begin
      next_s.misc[MR_AUX_FLAG] = 1'b1;
      next_s.irq_status[1] = 1'b1;
    end
    next_s.misc[MR_PS1_PRE] = 1'b0;
    next_s.misc[MR_PS2_PRE] = 1'b0;
    next_s.readdata = UNMAPPED_RD;
    if (rd && !s.rd_done) begin
      if (avs_address == OFS_PORTA) begin
        next_s.readdata = {24'h00_0000, pa_rd};
      end else if (avs_address == OFS_PORTB) begin
        next_s.readdata = {28'h000_0000, pb_rd};
      end else if (avs_address == OFS_PORTC) begin
        next_s.readdata = {30'h0000_0000, pc_rd};
      end else if (avs_address == OFS_PORTA_DIR || avs_address == OFS_PORTB_DCR
                   || avs_address == OFS_PORTC_DIR) begin
        next_s.readdata = {24'h00_0000, READS_ONES};
      end else if (avs_address == OFS_MISC) begin
        next_s.readdata = {24'h00_0000, s.misc};
      end else if (avs_address == OFS_IRQ_STAT) begin
        next_s.readdata = {30'h0000_0000, s.irq_status};
      end else if (avs_address == OFS_IRQ_MASK) begin
        next_s.readdata = {30'h0000_0000, s.irq_mask};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s                    <= '0;
      s.portb_data_control <= DCR_RESET;
      s.misc               <= MISC_RESET;
      s.irq2_sync          <= 2'b11;
      s.irq2_prev          <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Prescaler preset strobes are one-cycle pulses from the write itself
  always_comb begin
    first_prescaler_preset  = wr && avs_address == OFS_MISC && wd[MR_PS1_PRE];
    second_prescaler_preset = wr && avs_address == OFS_MISC && wd[MR_PS2_PRE];
    aux_counter_preset      = aux_wr_preset;
  end

  assign timer_a_clk_sel     = s.misc[MR_PS_SWAP] ? prescaler2_out : prescaler1_out;
  assign timer_b_clk_sel     = s.misc[MR_PS_SWAP] ? prescaler1_out : prescaler2_out;
  assign reset_pin_pulldown  = s.misc[MR_AUX_FLAG] & ~s.misc[MR_AUX_MASK];
  assign ext_irq_two_request = s.misc[MR_IRQ2_FLAG] & ~s.misc[MR_IRQ2_MASK];
  assign irq                 = |(s.irq_status & s.irq_mask);

  assign porta_out = s.porta_data;
  assign porta_oe  = s.porta_direction;
  assign portb_out = s.portb_data;
  assign portc_out = s.portc_data;
  assign portc_oe  = s.portc_direction;
  // Open-drain lines drive only while the latch is low
  always_comb begin
    portb_oe[0] = s.portb_data_control[0];
    for (int i = 1; i < 4; i++) begin
      portb_oe[i] = s.portb_data_control[i]
                    & (s.portb_data_control[4+i] | ~s.portb_data[i]);
    end
  end
endmodule : ptmc_top
`default_nettype wire
